// ### logic/fault_guard.sv
// fault response and mode guard with ahb-lite registers and fuse row
// assumes sensors, detectors and strap inputs are asynchronous levels
// Summary of operation
// - analog sensor alarms force a reset
// - light detector and fault detectors raise exceptions
// - light detection: function a, b or off
// - fault detectors on pc, sp, psw, coprocessors
// - inverse ecc errors raise an exception
// - pin reset restores all but fuse state; forced reset keeps reset cause and bus state; reset cause readable
// - exception cause bits readable by software
// - sensors forced on outside test mode
// - three stack limits each raise an exception
// - high-voltage check only readable, no event
// - eeprom reads correct single-bit byte errors
// - rom parity error forces a reset
// - boot first, then test, system or halt mode
// - boot may go on; nothing returns to boot
// - boot mode only right after reset
// - disabled test mode stays blocked forever
// - super-system flag selects contactless mode afterwards
// - guard top 128 eeprom bytes as fuse row
// - 32-byte area is read-only
// - 16-byte area writable until protected
// - write-once area bits only set
// - disabled card never starts application
`timescale 1ns/10ps
`include "fault_guard_consts.svh"
module fault_guard
	import fault_guard_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [11:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// asynchronous alarm levels
	input  wire logic [3:0]  sensor_alarm_i,   // volt, freq, temp, light
	input  wire logic        rom_parity_err_i,
	input  wire logic [1:0]  ee_light_i,       // function a and b alarms
	input  wire logic [4:0]  single_fault_i,   // pc sp psw cipher arith
	input  wire logic        ecc_err_i,
	input  wire logic [2:0]  stack_limit_i,    // user system super-system
	input  wire logic        hv_ok_i,
	input  wire logic        test_avail_i,     // hardware strap
	input  wire logic        super_system_flag_i,
	input  wire logic        boot_done_i,      // end of boot phase
	// eeprom data correction path
	input  wire logic [11:0] ee_code_i,        // 8 data + 4 check bits
	output logic      [7:0]  ee_data_o,
	// responses
	output logic             force_reset_o,
	output logic             exception_o,
	output logic             sensor_en_o,
	output logic [4:0]       cpu_mode_o,
	output logic             app_start_o
);
	initial begin
		if (`FG_RO_LEN + `FG_WP_LEN + `FG_WO_LEN > `FG_ROW_BYTES) begin
			$error("fuse row areas exceed the row");
		end
	end
	// hamming(12,8) corrector; check bits at positions 1,2,4,8
	function automatic logic [7:0] ecc_fix(input logic [11:0] c);
		logic [3:0]  s;
		logic [11:0] f;
		s = 4'h0;
		f = c;
		for (int i = 1; i <= 12; i++) begin
			if (c[i-1]) begin
				s = s ^ 4'(i);
			end
		end
		if (s != 4'h0 && s <= 4'd12) begin
			f[s-1] = ~c[s-1];
		end
		return {f[11], f[10], f[9], f[8], f[6], f[5], f[4], f[2]};
	endfunction
	// synchronised alarms
	localparam int NA = 20;
	logic [NA-1:0] alarm_s;
	fault_sync #(.W(NA)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({super_system_flag_i, boot_done_i, test_avail_i,
			hv_ok_i, stack_limit_i, ecc_err_i, single_fault_i,
			ee_light_i, rom_parity_err_i, sensor_alarm_i}),
		.sync_o    (alarm_s)
	);
	wire logic [3:0] sens_s   = alarm_s[3:0];
	wire logic       rompar_s = alarm_s[4];
	wire logic [1:0] ld_s     = alarm_s[6:5];
	wire logic [4:0] sf_s     = alarm_s[11:7];
	wire logic       ecc_s    = alarm_s[12];
	wire logic [2:0] stk_s    = alarm_s[15:13];
	wire logic       hv_s     = alarm_s[16];
	wire logic       tav_s    = alarm_s[17];
	wire logic       bdone_s  = alarm_s[18];
	wire logic       ssm_s    = alarm_s[19];
	// state
	logic [7:0]  ctrl_q;          // control register
	logic [`FG_RST_W-1:0] rcause_q;   // reset cause, survives core reset
	logic [`FG_EXC_W-1:0] ecause_q;   // sticky exception cause
	cpu_mode_e   mode_q;
	logic        booted_q;        // boot phase already left
	logic        hv_q;            // last high-voltage result
	logic        frst_q;          // forced reset pulse
	logic        exc_q;
	logic [6:0]  row_addr_q;
	// fuse state has no reset; power-up values only, held across resets
	logic [7:0]  row_q [`FG_ROW_BYTES] = '{default: 8'h00};  // fuse row
	logic [`FG_WP_LEN-1:0] wp_q = '0;  // per-byte protection, persistent
	logic        test_dis_q = 1'b0;    // persistent test disable fuse
	logic        card_dis_q = 1'b0;    // persistent card disable fuse
	logic        sensor_en_q;     // registered sensor enable
	logic        app_q;           // registered application start
	logic        last_ign_q;      // last row write ignored
	logic [31:0] hrdata_q;
	logic [7:0]  ee_q;
	// bus address phase capture
	logic        wr_ph_q;
	logic        rd_ph_q;
	logic [11:0] addr_q;
	wire logic   take = hsel_i & hready_i & htrans_i[1];
	wire logic   bus_wr = wr_ph_q;
	// reset sources hard-wired
	wire logic   rst_req = (|sens_s) | rompar_s;
	// light detector selection
	wire logic [1:0] ld_sel = ctrl_q[`FG_CTRL_LD_SEL_LSB +: 2];
	wire logic   ld_hit = (ld_sel == LD_FN_A && ld_s[0]) |
		(ld_sel == LD_FN_B && ld_s[1]);
	// exception events
	wire logic [`FG_EXC_W-1:0] exc_ev = {stk_s,
		ecc_s & ctrl_q[`FG_CTRL_INV_ECC], sf_s, ld_hit};
	// software write-one-to-clear, hardware set wins
	wire logic   wr_ecause = bus_wr && addr_q == `FG_OFF_EXC_CAUSE;
	wire logic [`FG_EXC_W-1:0] ecause_d = exc_ev |
		(ecause_q & ~(wr_ecause ? hwdata_i[`FG_EXC_W-1:0] : '0));
	// fuse row write decode
	wire logic   wr_row = bus_wr && addr_q == `FG_OFF_ROW_DATA;
	wire logic   in_ro = row_addr_q < 7'(`FG_RO_LEN);
	wire logic   in_wp = row_addr_q >= `FG_WP_BASE &&
		row_addr_q < `FG_WP_BASE + 7'(`FG_WP_LEN);
	wire logic   in_wo = row_addr_q >= `FG_WO_BASE &&
		row_addr_q < `FG_WO_BASE + 7'(`FG_WO_LEN);
	wire logic [3:0] wp_idx = 4'(row_addr_q - `FG_WP_BASE);
	wire logic   row_ok = in_wo | (in_wp & ~wp_q[wp_idx]);
	wire logic [7:0] row_new = in_wo ?
		(row_q[row_addr_q] | hwdata_i[7:0]) : hwdata_i[7:0];
	// next mode
	cpu_mode_e   mode_d;
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_BOOT: begin
				if (bdone_s) begin
					if (tav_s && !test_dis_q) begin
						mode_d = MODE_TEST;
					end else if (card_dis_q) begin
						mode_d = MODE_HALT;
					end else begin
						mode_d = MODE_SYSTEM;
					end
				end
			end
			MODE_TEST, MODE_CLESS: begin
				mode_d = mode_q;
			end
			MODE_SYSTEM: begin
				if (ssm_s) begin
					mode_d = MODE_CLESS;
				end
			end
			MODE_HALT: begin
				mode_d = MODE_HALT;
			end
			default: begin
				mode_d = MODE_HALT;
			end
		endcase
	end
	// bus read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (haddr_i)
			`FG_OFF_CTRL:      rd_mux = {24'h0, ctrl_q};
			`FG_OFF_RST_CAUSE: rd_mux = 32'(rcause_q);
			`FG_OFF_EXC_CAUSE: rd_mux = 32'(ecause_q);
			`FG_OFF_MODE:      rd_mux = {27'h0, mode_q};
			`FG_OFF_HV:        rd_mux = {31'h0, hv_q};
			`FG_OFF_ROW_ADDR:  rd_mux = {25'h0, row_addr_q};
			`FG_OFF_ROW_DATA:  rd_mux = {24'h0, row_q[row_addr_q]};
			`FG_OFF_ROW_STAT:  rd_mux = {30'h0, last_ign_q, |wp_q};
			default:           rd_mux = 32'h0;
		endcase
	end
	// bus phase tracking
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_ph_q  <= 1'b0;
			rd_ph_q  <= 1'b0;
			addr_q   <= 12'h000;
			hrdata_q <= 32'h0;
		end else begin
			wr_ph_q  <= take & hwrite_i;
			rd_ph_q  <= take & ~hwrite_i;
			addr_q   <= haddr_i;
			hrdata_q <= (take & ~hwrite_i) ? rd_mux : 32'h0;
		end
	end
	// control, exception cause and mode; a reset clears all but mode_q (MODE_BOOT) and sensor_en_q (set to 1)
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || frst_q) begin
			ctrl_q   <= `FG_CTRL_RST;
			ecause_q <= '0;
			mode_q   <= MODE_BOOT;
			booted_q <= 1'b0;
			hv_q     <= 1'b0;
			exc_q    <= 1'b0;
			row_addr_q <= 7'h00;
			sensor_en_q <= 1'b1;
			app_q       <= 1'b0;
		end else begin
			if (bus_wr && addr_q == `FG_OFF_CTRL) begin
				ctrl_q <= hwdata_i[7:0];
			end
			if (bus_wr && addr_q == `FG_OFF_ROW_ADDR) begin
				row_addr_q <= hwdata_i[6:0];
			end
			ecause_q <= ecause_d;
			exc_q    <= |exc_ev;
			hv_q     <= hv_s;
			mode_q   <= mode_d;
			// outputs follow the next mode so they stay flop-driven
			sensor_en_q <= (mode_d != MODE_TEST);
			app_q       <= (mode_d == MODE_SYSTEM);
			booted_q <= booted_q | (mode_q != MODE_BOOT);
		end
	end
	// reset cause: set to the pin bit only by pin reset, overwritten with the sources on forced reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rcause_q <= `FG_RST_W'(1) << `FG_RST_PIN;
			frst_q   <= 1'b0;
		end else begin
			frst_q <= rst_req & ~frst_q;
			if (rst_req & ~frst_q) begin
				rcause_q <= {1'b0, rompar_s, sens_s};
			end
		end
	end
	// persistent fuses: write protect, test and card disable
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			last_ign_q <= 1'b0;
		end else begin
			if (wr_row && !in_ro) begin
				if (row_ok) begin
					row_q[row_addr_q] <= row_new;
				end
				last_ign_q <= ~row_ok;
			end else if (wr_row) begin
				last_ign_q <= 1'b1;
			end
			if (ctrl_q[`FG_CTRL_WP_LOCK] && in_wp) begin
				wp_q[wp_idx] <= 1'b1;
			end
			if (ctrl_q[`FG_CTRL_TEST_DIS]) begin
				test_dis_q <= 1'b1;
			end
			if (ctrl_q[`FG_CTRL_CARD_DIS]) begin
				card_dis_q <= 1'b1;
			end
		end
	end
	// eeprom read correction
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ee_q <= 8'h00;
		end else begin
			ee_q <= ecc_fix(ee_code_i);
		end
	end
	assign hrdata_o      = hrdata_q;
	assign hreadyout_o   = 1'b1;
	assign hresp_o       = 1'b0;
	assign ee_data_o     = ee_q;
	assign force_reset_o = frst_q;
	assign exception_o   = exc_q;
	assign sensor_en_o   = sensor_en_q;
	assign cpu_mode_o    = mode_q;
	assign app_start_o   = app_q;
	// assertions
	a_sensor_reset: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) $rose(|sens_s) && !frst_q |=> force_reset_o)
		else $error("sensor alarm did not force reset");
	a_rom_reset: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) $rose(rompar_s) && !frst_q |=> force_reset_o)
		else $error("rom parity did not force reset");
	a_fault_exc: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i || frst_q) (|sf_s) |=> exception_o)
		else $error("fault detector gave no exception");
	a_exc_cause: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i || frst_q) exc_ev[0] |=> ecause_q[0])
		else $error("exception cause not recorded");
	a_hv_no_event: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) $changed(hv_s) && exc_ev == '0 &&
		!rst_req |=> !exception_o && !force_reset_o)
		else $error("high-voltage check raised an event");
	a_no_boot_back: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i || frst_q) booted_q |-> mode_q != MODE_BOOT)
		else $error("returned to boot mode");
	a_sensor_on: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) mode_q != MODE_TEST |-> sensor_en_o)
		else $error("sensors off outside test mode");
	a_test_block: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) test_dis_q && mode_q == MODE_BOOT
		|=> mode_q != MODE_TEST)
		else $error("test mode entered after disable");
	a_card_off: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) card_dis_q && mode_q == MODE_BOOT
		|=> !app_start_o)
		else $error("disabled card started application");
	a_rd_idle: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !rd_ph_q |-> hrdata_o == 32'h0)
		else $error("read data not zero outside data phase");
	a_ro_ignore: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) wr_row && in_ro |=> last_ign_q &&
		row_q[$past(row_addr_q)] == $past(row_q[row_addr_q]))
		else $error("read-only byte was written");
	a_wp_ignore: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) wr_row && in_wp && wp_q[wp_idx] |=>
		last_ign_q &&
		row_q[$past(row_addr_q)] == $past(row_q[row_addr_q]))
		else $error("protected byte was written");
	a_wo_sticky: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) wr_row && in_wo |=>
		(row_q[$past(row_addr_q)] | $past(row_q[row_addr_q])) ==
		row_q[$past(row_addr_q)])
		else $error("write-once bit returned to zero");
endmodule

// ### logic/fault_guard_consts.svh
// constants for the fault response and mode guard: offsets, fields, counts
// assumes inclusion by bare name from the package and the design modules
`ifndef FAULT_GUARD_CONSTS_SVH
`define FAULT_GUARD_CONSTS_SVH
// register byte offsets
`define FG_OFF_CTRL      12'h000
`define FG_OFF_RST_CAUSE 12'h004
`define FG_OFF_EXC_CAUSE 12'h008
`define FG_OFF_MODE      12'h00c
`define FG_OFF_HV        12'h010
`define FG_OFF_ROW_ADDR  12'h014
`define FG_OFF_ROW_DATA  12'h018
`define FG_OFF_ROW_STAT  12'h01c
// control fields
`define FG_CTRL_LD_SEL_LSB 0
`define FG_CTRL_INV_ECC    2
`define FG_CTRL_WP_LOCK    3
`define FG_CTRL_CARD_DIS   4
`define FG_CTRL_TEST_DIS   5
// fuse row layout, byte indices in the 128-byte row
`define FG_ROW_BYTES   128
`define FG_RO_BASE     7'h00
`define FG_RO_LEN      32
`define FG_WP_BASE     7'h20
`define FG_WP_LEN      16
`define FG_WO_BASE     7'h30
`define FG_WO_LEN      32
// reset values
`define FG_CTRL_RST    8'h00
// exception cause bits
`define FG_EXC_LIGHT   0
`define FG_EXC_PC      1
`define FG_EXC_SP_F    2
`define FG_EXC_PSW     3
`define FG_EXC_CIPH    4
`define FG_EXC_ARITH   5
`define FG_EXC_ECC     6
`define FG_EXC_STK_U   7
`define FG_EXC_STK_S   8
`define FG_EXC_STK_SS  9
`define FG_EXC_W       10
// reset cause bits
`define FG_RST_VOLT    0
`define FG_RST_FREQ    1
`define FG_RST_TEMP    2
`define FG_RST_LIGHT   3
`define FG_RST_ROMPAR  4
`define FG_RST_PIN     5
`define FG_RST_W       6
`endif

// ### logic/fault_guard_pkg.sv
// types for the fault response and mode guard
// assumes the constants header sits in the include path
package fault_guard_pkg;
	`include "fault_guard_consts.svh"
	// cpu privilege modes, one-hot
	typedef enum logic [4:0] {
		MODE_BOOT   = 5'b00001,
		MODE_TEST   = 5'b00010,
		MODE_CLESS  = 5'b00100,
		MODE_SYSTEM = 5'b01000,
		MODE_HALT   = 5'b10000
	} cpu_mode_e;
	// light detector function selection
	typedef enum logic [1:0] {
		LD_OFF = 2'b00,
		LD_FN_A = 2'b01,
		LD_FN_B = 2'b10
	} light_sel_e;
endpackage

// ### logic/fault_sync.sv
// two-flop synchroniser for a bundle of asynchronous level inputs
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module fault_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;   // first stage, read only by stage two
	logic [W-1:0] sync_q;   // second stage
	initial begin
		if (W < 1) begin
			$error("fault_sync width must be at least one");
		end
	end
	// two stages, reset clears both
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule

// ### tb/ee_model.sv
// ecc byte model: hamming encodes a byte, may flip one code bit
// assumes the bench drives data and flip position
`timescale 1ns/10ps
module ee_model (
	input  wire logic [7:0]  data_i,
	input  wire logic [3:0]  flip_i,  // 4'hf: no flip
	output logic      [11:0] code_o
);
	logic [11:0] c;  // clean code word
	// parity bits at positions 1,2,4,8, even parity
	always_comb begin
		c = '0;
		{c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]} = data_i;
		c[0] = c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
		c[1] = c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
		c[3] = c[4] ^ c[5] ^ c[6] ^ c[11];
		c[7] = c[8] ^ c[9] ^ c[10] ^ c[11];
		code_o = c;
		if (flip_i < 4'hc)
			code_o[flip_i] = ~c[flip_i];  // single-bit upset
	end
endmodule

// ### tb/tb.sv
// self-checking bench for the fault response and mode guard
// assumes the ecc model and the design files compile first
`timescale 1ns/10ps
module tb;
	import fault_guard_pkg::*;
	logic        clk = 0, rst_n = 0;
	logic        hsel = 0, hwr = 0, hro, hresp;
	logic [11:0] ha = '0, code;
	logic [1:0]  ht = '0;
	logic [2:0]  hsz = '0;
	logic [31:0] hwd = '0, rd, hrdata;
	logic [3:0]  sens = '0, flip = 4'hf;
	logic        rom = 0, lb = 0, hv = 0, tav = 0, ssf = 0, bd = 0;
	logic [9:0]  ev = '0;  // light a, faults, ecc, stacks
	logic [7:0]  byt = '0, edo;
	logic        frc, exc, sen, app;
	logic [4:0]  mode;
	int          fail_count = 0, checked = 0, cyc = 0, i;
	fault_guard dut (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
		.haddr_i(ha), .htrans_i(ht), .hwrite_i(hwr), .hsize_i(hsz),
		.hwdata_i(hwd), .hready_i(hro), .hrdata_o(hrdata),
		.hreadyout_o(hro), .hresp_o(hresp), .sensor_alarm_i(sens),
		.rom_parity_err_i(rom), .ee_light_i({lb, ev[0]}),
		.single_fault_i(ev[5:1]), .ecc_err_i(ev[6]),
		.stack_limit_i(ev[9:7]), .hv_ok_i(hv), .test_avail_i(tav),
		.super_system_flag_i(ssf), .boot_done_i(bd), .ee_code_i(code),
		.ee_data_o(edo), .force_reset_o(frc), .exception_o(exc),
		.sensor_en_o(sen), .cpu_mode_o(mode), .app_start_o(app));
	ee_model em (.data_i(byt), .flip_i(flip), .code_o(code));
	// clock, 8 ns period
	initial begin
		forever #4 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			$display("MISMATCH %0t timeout", $time);
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// word compare
	task automatic chk(input logic [31:0] g, e, input string m);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// flag compare
	task automatic chkb(input logic g, e, input string m);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one ahb-lite single word transfer, read data left in rd
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		ht <= 2'h2;
		ha <= a;
		hwr <= w;
		hsz <= 3'h2;
		do @(posedge clk); while (hro !== 1'b1);
		hsel <= 1'b0;
		ht <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hro !== 1'b1);
		rd = hrdata;
	endtask
	task automatic prst;
		@(posedge clk);
		rst_n <= 1'b0;
		cy(2);
		rst_n <= 1'b1;
		cy(1);
	endtask
	task automatic t_init;
		chk(mode, MODE_BOOT, "boot");
		chkb(sen, 1, "sensors");
		bus(0, 12'h000, 0);
		chk(rd, 32'h0, "ctrl");
		bus(0, 12'h004, 0);
		chkb(rd[5], 1, "pin cause");
		bus(0, 12'h040, 0);
		chk(rd, 32'h0, "unmapped");
		chkb(hresp, 1'b0, "okay");
		bus(0, 12'h00c, 0);
		chk(rd, MODE_BOOT, "mode reg");
		$display("init done");
	endtask
	task automatic t_hv;
		hv <= 1'b1;
		cy(6);
		bus(0, 12'h010, 0);
		chkb(rd[0], 1, "hv");
		chkb(exc | frc, 0, "hv event");
		hv <= 1'b0;
		cy(6);
		bus(0, 12'h010, 0);
		chkb(rd[0], 0, "hv low");
		$display("hv done");
	endtask
	task automatic t_rst;
		logic hit;
		for (i = 0; i < 5; i++) begin
			{rom, sens} <= 5'h1 << i;
			hit = 0;
			repeat (10) begin
				@(posedge clk);
				hit |= (frc === 1'b1);
			end
			chkb(hit, 1, "forced");
			chkb(exc, 0, "no exc");
			{rom, sens} <= '0;
			cy(8);
			bus(0, 12'h004, 0);
			chkb(rd[i], 1, "rst cause");
		end
		$display("reset causes done");
	endtask
	task automatic t_exc;
		bus(1, 12'h000, 32'h5);
		for (i = 0; i < 10; i++) begin
			ev <= 10'h1 << i;
			cy(6);
			chkb(exc, 1, "exc");
			bus(0, 12'h008, 0);
			chk(rd, 32'h1 << i, "cause");
			ev <= '0;
			cy(6);
			bus(1, 12'h008, 32'h1 << i);
			bus(0, 12'h008, 0);
			chk(rd, 32'h0, "clear");
			cy(4);
			chkb(exc, 0, "exc off");
		end
		bus(1, 12'h000, 32'h2);
		lb <= 1'b1;
		cy(6);
		bus(0, 12'h008, 0);
		chk(rd, 32'h1, "light b");
		lb <= 1'b0;
		cy(6);
		bus(1, 12'h008, 32'h1);
		bus(1, 12'h000, 32'h0);
		{lb, ev} <= 11'h441;
		cy(6);
		chkb(exc, 0, "off");
		{lb, ev} <= '0;
		cy(6);
		$display("exceptions done");
	endtask
	task automatic t_row;
		logic [31:0] o;
		bus(1, 12'h014, 32'h1f);
		bus(0, 12'h018, 0);
		o = rd;
		bus(1, 12'h018, ~o & 32'hff);
		bus(0, 12'h018, 0);
		chk(rd, o, "ro");
		bus(0, 12'h01c, 0);
		chkb(rd[1], 1, "ignored");
		bus(1, 12'h014, 32'h30);
		bus(0, 12'h018, 0);
		o = rd | 32'h5a;
		bus(1, 12'h018, 32'h5a);
		bus(1, 12'h018, 32'h0);
		bus(0, 12'h018, 0);
		chk(rd, o, "wo");
		bus(1, 12'h014, 32'h2f);
		bus(1, 12'h018, 32'h3c);
		bus(0, 12'h018, 0);
		chk(rd, 32'h3c, "wp");
		bus(1, 12'h000, 32'h8);
		prst;
		bus(1, 12'h014, 32'h2f);
		bus(1, 12'h018, 32'hc3);
		bus(0, 12'h018, 0);
		chk(rd, 32'h3c, "locked");
		bus(0, 12'h01c, 0);
		chk(rd[1:0], 32'h3, "stat");
		$display("fuse row done");
	endtask
	task automatic t_ecc;
		for (i = 0; i < 13; i++) begin
			byt <= 8'ha5 ^ i[7:0];
			flip <= (i == 12) ? 4'hf : i[3:0];
			cy(2);
			chk(edo, 8'ha5 ^ i[7:0], "ecc");
		end
		$display("ecc done");
	endtask
	// reset, set control during boot, end boot, check mode
	task automatic go(input logic [31:0] c, input logic t,
		input logic [4:0] m);
		bd <= 1'b0;
		tav <= t;
		prst;
		bus(1, 12'h000, c);
		bd <= 1'b1;
		cy(8);
		chk(mode, m, "mode");
	endtask
	task automatic t_mode;
		go(0, 0, MODE_SYSTEM);
		chkb(app, 1, "app");
		chkb(sen, 1, "sens on");
		ssf <= 1'b1;
		cy(8);
		chk(mode, MODE_CLESS, "cless");
		ssf <= 1'b0;
		bd <= 1'b0;
		cy(8);
		chk(mode, MODE_CLESS, "no boot");
		go(0, 1, MODE_TEST);
		chkb(sen, 0, "test sens");
		go(32'h20, 1, MODE_SYSTEM);
		go(32'h10, 0, MODE_HALT);
		chkb(app, 0, "no app");
		prst;
		chk(mode, MODE_BOOT, "reboot");
		$display("modes done");
	endtask
	initial begin
		cy(20);
		rst_n <= 1'b1;
		cy(1);
		t_init;
		t_hv;
		t_rst;
		t_exc;
		t_row;
		t_ecc;
		t_mode;
		wrap_up;
	end
endmodule
